// file: bench/tlip_bench.sv
// self-checking bench for the interrupt prioritizer
`timescale 1ns/1ps
`default_nettype none
module tlip_bench;
	import tlip_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b1;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, reti = 1'b0, ins = 1'b0;
	logic [ADDR_W-1:0] awa = '0, ara = '0;
	logic [DATA_W-1:0] wd = '0;
	logic [NUM_SRC-1:0] pend = '0;
	logic [2:0] aw8 = 3'h4;
	wire awr, wrd, bv, arr, rv, call, ack;
	wire [1:0] bre, rre;
	wire [DATA_W-1:0] rda;
	wire [VEC_W-1:0] vec;
	int errors = 0, checked = 0;
	integer seed = 88;
	logic lazy = 1'b0;
	logic [3:0] ws = 4'hf;
	always #5 clk = ~clk;
	tlip_top u_dut (.REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(en), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
		.S_AXI_BRESP(bre), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rda), .S_AXI_RRESP(rre),
		.IRQ_PENDING(pend), .CALL_REQ(call), .CALL_VECTOR(vec), .CALL_ACK(ack),
		.RETI_DONE(reti), .INSTR_DONE(ins));
	tlip_core_model u_core (.clk(clk), .rst_n(rst_n), .call_req(call), .ack_wait(aw8),
		.call_ack(ack));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : complete_run
	task automatic tick(inout int k);
		@(negedge clk);
		k++;
		if (k > 60) begin
			errors++;
			complete_run();
		end
	endtask : tick
	// ==========================================================
	// register bus master
	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic ta, tw, da, dw;
		int k;
		@(posedge clk);
		awa <= {idx, 2'b00};
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= !lazy;
		k = 0;
		da = 1'b0;
		dw = 1'b0;
		while (!(da && dw)) begin
			tick(k);
			ta = awr & !da;
			tw = wrd & !dw;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			da = da | ta;
			dw = dw | tw;
		end
		do tick(k); while (bv !== 1'b1);
		check({30'h0, bre}, {30'h0, er});
		// late ready keeps the response standing one cycle
		if (lazy) begin
			@(posedge clk);
			bry <= 1'b1;
		end
		@(posedge clk);
		bry <= 1'b0;
		lazy = !lazy;
	endtask : wr
	task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
		int k;
		@(posedge clk);
		ara <= {idx, 2'b00};
		arv <= 1'b1;
		rry <= !lazy;
		k = 0;
		do tick(k); while (arr !== 1'b1);
		@(posedge clk);
		arv <= 1'b0;
		do tick(k); while (rv !== 1'b1);
		check(rda, {24'h0, d});
		check({30'h0, rre}, {30'h0, er});
		if (lazy) begin
			@(posedge clk);
			rry <= 1'b1;
		end
		@(posedge clk);
		rry <= 1'b0;
		lazy = !lazy;
	endtask : rd
	// ==========================================================
	// core side
	task automatic pulse(input logic r);
		@(posedge clk);
		reti <= r;
		ins <= !r;
		@(posedge clk);
		reti <= 1'b0;
		ins <= 1'b0;
	endtask : pulse
	task automatic take_call(input logic [15:0] v, input int lat, input logic [21:0] keep);
		int k;
		k = 0;
		do tick(k); while (call !== 1'b1);
		if (lat > 0) check(k, lat);
		check({16'h0, vec}, {16'h0, v});
		@(posedge clk);
		pend <= pend & keep;
		do tick(k); while (call !== 1'b0);
		@(posedge clk);
	endtask : take_call
	task automatic no_call();
		logic seen;
		seen = 1'b0;
		repeat (8) begin
			@(negedge clk);
			seen = seen | call;
		end
		check({31'h0, seen}, 32'h0);
		@(posedge clk);
	endtask : no_call
	// winner: high level first, then lowest index
	function automatic int best(input logic [21:0] p, input logic [7:0] ie, input logic [7:0] e1,
		input logic [5:0] pr);
		logic [21:0] m;
		logic [21:0] hp;
		int b;
		int h;
		m = ie[7] ? (p & {8'h00, e1, ie[5:0]}) : 22'h0;
		hp = m & {16'h0, pr};
		b = -1;
		h = -1;
		for (int i = 21; i >= 0; i--) begin
			if (m[i]) b = i;
			if (hp[i]) h = i;
		end
		return (h >= 0) ? h : b;
	endfunction : best
	initial begin
		logic [7:0] ie, e1;
		logic [5:0] pr;
		logic [21:0] p;
		int b;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(IDX_ENABLE_MAIN, 8'h00, RESP_OKAY);
		rd(IDX_PRIORITY_MAIN, 8'hc0, RESP_OKAY);
		rd(IDX_ENABLE_EXT1, 8'h00, RESP_OKAY);
		rd(10'h001, 8'h00, RESP_SLVERR);
		wr(IDX_PRIORITY_MAIN, 8'h3f, RESP_OKAY);
		rd(IDX_PRIORITY_MAIN, 8'hff, RESP_OKAY);
		wr(IDX_ENABLE_MAIN, 8'h7f, RESP_OKAY);
		rd(IDX_ENABLE_MAIN, 8'h7f, RESP_OKAY);
		ws <= 4'he;
		wr(IDX_ENABLE_MAIN, 8'h00, RESP_OKAY);
		ws <= 4'hf;
		rd(IDX_ENABLE_MAIN, 8'h7f, RESP_OKAY);
		wr(10'h001, 8'h00, RESP_SLVERR);
		wr(IDX_STATUS, 8'hff, RESP_OKAY);
		rd(IDX_STATUS, 8'h00, RESP_OKAY);
		pend <= '1;
		no_call();
		pend <= '0;
		for (int i = 0; i < 40; i++) begin
			ie = 8'($random(seed));
			e1 = 8'($random(seed));
			pr = 6'($random(seed));
			p = 22'($random(seed));
			wr(IDX_ENABLE_MAIN, ie, RESP_OKAY);
			wr(IDX_ENABLE_EXT1, e1, RESP_OKAY);
			wr(IDX_PRIORITY_MAIN, {2'h0, pr}, RESP_OKAY);
			aw8 <= 3'($random(seed));
			pend <= p;
			b = best(p, ie, e1, pr);
			if (b < 0) no_call();
			else take_call(16'h0003 + 16'(b) * 16'h0008, 2, '0);
			pend <= '0;
			pulse(1'b1);
			pulse(1'b0);
		end
		wr(IDX_PRIORITY_MAIN, 8'h01, RESP_OKAY);
		wr(IDX_ENABLE_MAIN, 8'h83, RESP_OKAY);
		// frozen enable: request waits, then detect takes one cycle
		en <= 1'b0;
		pend <= 22'h2;
		no_call();
		en <= 1'b1;
		take_call(16'h000b, 2, 22'h2);
		pend <= 22'h3;
		take_call(16'h0003, 2, 22'h2);
		rd(IDX_STATUS, 8'h03, RESP_OKAY);
		no_call();
		pulse(1'b1);
		pulse(1'b0);
		no_call();
		pulse(1'b1);
		no_call();
		pulse(1'b0);
		take_call(16'h000b, 0, '0);
		pulse(1'b1);
		pulse(1'b0);
		complete_run();
	end
endmodule : tlip_bench
`default_nettype wire

// file: bench/tlip_core_model.sv
// core sequencer model that takes offered calls
`timescale 1ns/1ps
`default_nettype none
module tlip_core_model (
	// clock, reset
	input wire logic clk,
	input wire logic rst_n,
	// call port
	input wire logic call_req,
	input wire logic [2:0] ack_wait,
	output logic call_ack
);
	logic [2:0] cnt_r;
	// ack after ack_wait stalled cycles, one pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 3'h0;
			call_ack <= 1'b0;
		end else begin
			call_ack <= 1'b0;
			if (call_req && !call_ack) begin
				cnt_r <= (cnt_r >= ack_wait) ? 3'h0 : cnt_r + 3'h1;
				call_ack <= (cnt_r >= ack_wait);
			end
		end
	end
endmodule : tlip_core_model
`default_nettype wire

// file: bench/tlip_monitor.sv
// port checker for the interrupt prioritizer
`timescale 1ns/1ps
`default_nettype none
module tlip_monitor (
	// clock, reset
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	// register bus
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [tlip_pkg::DATA_W-1:0] S_AXI_RDATA,
	// sources and core
	input wire logic [tlip_pkg::NUM_SRC-1:0] IRQ_PENDING,
	input wire logic CALL_REQ,
	input wire logic [tlip_pkg::VEC_W-1:0] CALL_VECTOR,
	input wire logic CALL_ACK,
	input wire logic RETI_DONE,
	input wire logic INSTR_DONE
);
	import tlip_pkg::*;
	logic wait_r;
	logic [4:0] vidx;
	assign vidx = CALL_VECTOR[7:3];
	// set after a return, until the next instruction
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) wait_r <= 1'b0;
		else if (CLK_EN) wait_r <= (RETI_DONE & ~CALL_REQ) | (wait_r & ~INSTR_DONE);
	end
	default clocking dcb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	// ==========================================================
	// core port
	chk_call_stands: assert property (CALL_REQ && !(CALL_ACK && CLK_EN) |=> CALL_REQ && $stable(CALL_VECTOR))
		else $error("call offer changed before ack");
	chk_call_taken: assert property (CALL_REQ && CALL_ACK && CLK_EN |=> !CALL_REQ)
		else $error("call offer stayed after ack");
	chk_vector_layout: assert property (CALL_REQ |-> CALL_VECTOR[2:0] == 3'h3 && CALL_VECTOR[15:8] == 8'h00 && vidx <= 5'd21)
		else $error("vector outside the table");
	chk_call_cause: assert property ($rose(CALL_REQ) |-> |($past(IRQ_PENDING) & (22'h1 << vidx)))
		else $error("call for a source not pending");
	chk_return_gap: assert property ($rose(CALL_REQ) |-> !$past(wait_r) || $past(INSTR_DONE))
		else $error("call before next instruction after return");
	// ==========================================================
	// register bus
	chk_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	chk_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped early");
	chk_rdata_byte: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
		else $error("address taken while response pending");
	cover property (CALL_REQ && CALL_ACK);
	cover property ($rose(CALL_REQ) && $past(INSTR_DONE));
	cover property (S_AXI_BVALID && S_AXI_BREADY);
	cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule : tlip_monitor
bind tlip_top tlip_monitor u_mon (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .IRQ_PENDING(IRQ_PENDING), .CALL_REQ(CALL_REQ),
	.CALL_VECTOR(CALL_VECTOR), .CALL_ACK(CALL_ACK), .RETI_DONE(RETI_DONE),
	.INSTR_DONE(INSTR_DONE));
`default_nettype wire

// file: design/tlip_arb_if.sv
// request and winner signals between the controller and its resolver
`timescale 1ns/1ps
`default_nettype none
interface tlip_arb_if;
	import tlip_pkg::*;
	logic [NUM_SRC-1:0] req;
	logic [NUM_SRC-1:0] high;
	logic found;
	logic win_high;
	logic [IDX_W-1:0] win_idx;

	modport resolver (input req, input high, output found, output win_high, output win_idx);
	modport client (output req, output high, input found, input win_high, input win_idx);
endinterface : tlip_arb_if
`default_nettype wire

// file: design/tlip_pkg.sv
// constants and types shared by the two-level interrupt prioritizer
package tlip_pkg;

	// ==========================================================
	// source map
	localparam int NUM_SRC = 22;
	localparam int IDX_W = 5;
	localparam int MAIN_SRC_W = 6;
	localparam int EXT1_SRC_W = 8;
	localparam int UPPER_SRC_W = NUM_SRC - MAIN_SRC_W - EXT1_SRC_W;

	// ==========================================================
	// vector layout
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam int VEC_SHIFT = 3;
	localparam int VEC_W = 16;

	// ==========================================================
	// register bus
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int WIDX_W = ADDR_W - 2;
	localparam logic [WIDX_W-1:0] IDX_ENABLE_MAIN = 10'h0a8;
	localparam logic [WIDX_W-1:0] IDX_PRIORITY_MAIN = 10'h0b8;
	localparam logic [WIDX_W-1:0] IDX_ENABLE_EXT1 = 10'he6;
	localparam logic [WIDX_W-1:0] IDX_STATUS = 10'h0f0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// fields and reset values
	localparam int GLOBAL_EN_BIT = 7;
	localparam int SPARE_FLAG_BIT = 6;
	localparam int ST_ISR_LO_BIT = 0;
	localparam int ST_ISR_HI_BIT = 1;
	localparam int ST_CALL_BIT = 2;
	localparam int ST_IDX_LSB = 3;
	localparam logic [7:0] ENABLE_MAIN_RST = 8'h00;
	localparam logic [5:0] PRIORITY_MAIN_RST = 6'h00;
	localparam logic [7:0] ENABLE_EXT1_RST = 8'h00;
	localparam logic [1:0] PRIORITY_UNUSED_RD = 2'h3;

	// ==========================================================
	// sequencer states, gray along idle-call and idle-hold
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CALL = 2'h1,
		ST_HOLD = 2'h2
	} tlip_state_t;

endpackage : tlip_pkg

// file: design/tlip_resolver.sv
// combinational two-level fixed-order priority resolver
`timescale 1ns/1ps
`default_nettype none
module tlip_resolver (
	// request side
	tlip_arb_if.resolver arb
);
	import tlip_pkg::*;

	// ==========================================================
	// first-one chains per level
	logic [NUM_SRC:0] seen_hi;
	logic [NUM_SRC:0] seen_lo;
	logic [NUM_SRC-1:0] grant_hi;
	logic [NUM_SRC-1:0] grant_lo;
	logic [NUM_SRC-1:0] grant;
	logic [IDX_W-1:0] idx;

	assign seen_hi[0] = 1'b0;
	assign seen_lo[0] = 1'b0;

	genvar i;
	generate
		for (i = 0; i < NUM_SRC; i++) begin : g_chain
			wire req_hi = arb.req[i] & arb.high[i];
			wire req_lo = arb.req[i] & ~arb.high[i];
			assign grant_hi[i] = req_hi & ~seen_hi[i];
			assign grant_lo[i] = req_lo & ~seen_lo[i];
			assign seen_hi[i+1] = seen_hi[i] | req_hi;
			assign seen_lo[i+1] = seen_lo[i] | req_lo;
		end
	endgenerate

	// high level wins over low level
	assign grant = seen_hi[NUM_SRC] ? grant_hi : grant_lo;

	// ==========================================================
	// one-hot to index
	always_comb begin
		idx = '0;
		for (int k = 0; k < NUM_SRC; k++) begin
			if (grant[k]) begin
				idx = IDX_W'(k);
			end
		end
	end

	assign arb.win_idx = idx;
	assign arb.win_high = seen_hi[NUM_SRC];
	assign arb.found = seen_hi[NUM_SRC] | seen_lo[NUM_SRC];

endmodule : tlip_resolver
`default_nettype wire

// file: design/tlip_top.sv
// two-level interrupt prioritizer with register slave and core call port
//
// Summary of operation
// - each of the six main sources has one priority bit choosing low or high level; all other sources are always low.
// - high request preempts low routine; high routine is never preempted.
// - all priority bits reset to zero, so every source starts low.
// - high level beats low; equal level resolved by lowest source index.
// - 22 sources ranked 0..21; vector is 0x0003 plus eight times index.
// - pending requests are sampled and decoded in every clock cycle with CLK_EN high.
// - one detect cycle, then the core needs four cycles for the call.
// - after a return, one more instruction runs before the next call.
// - worst unblocked response is 18 cycles including return and divide.
// - equal or lower level waits for return plus next instruction.
// - global enable bit 7 low blocks all; high lets each enable act.
// - enable bit 6 is a spare software flag without effect.
// - main enable register holds six source enables in bits 5..0.
// - main priority register holds six level bits in same order.
// - top two priority bits read as ones and ignore writes.
// - extended enable register holds eight more source enables.
// - flag still set after return re-requests after next instruction.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tlip_top (
	// clock, reset, enable
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	// register bus write address
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [tlip_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	// register bus write data
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [tlip_pkg::DATA_W-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	// register bus write response
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	// register bus read address
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [tlip_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	// register bus read data
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [tlip_pkg::DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	// peripheral pending flags
	input wire logic [tlip_pkg::NUM_SRC-1:0] IRQ_PENDING,
	// core sequencer
	output logic CALL_REQ,
	output logic [tlip_pkg::VEC_W-1:0] CALL_VECTOR,
	input wire logic CALL_ACK,
	input wire logic RETI_DONE,
	input wire logic INSTR_DONE
);
	import tlip_pkg::*;

	// ==========================================================
	// declarations
	logic [REG_W-1:0] ie_main_r;
	logic [REG_W-1:0] ie_main_nxt;
	logic [MAIN_SRC_W-1:0] ip_main_r;
	logic [MAIN_SRC_W-1:0] ip_main_nxt;
	logic [REG_W-1:0] ie_ext1_r;
	logic [REG_W-1:0] ie_ext1_nxt;

	tlip_state_t state_r;
	tlip_state_t state_nxt;
	logic isr_lo_r;
	logic isr_lo_nxt;
	logic isr_hi_r;
	logic isr_hi_nxt;
	logic call_high_r;
	logic call_high_nxt;
	logic [IDX_W-1:0] call_idx_r;
	logic [IDX_W-1:0] call_idx_nxt;
	logic [VEC_W-1:0] call_vec_r;
	logic [VEC_W-1:0] call_vec_nxt;

	logic aw_held_r;
	logic [WIDX_W-1:0] aw_idx_r;
	logic w_held_r;
	logic [REG_W-1:0] w_data_r;
	logic w_lane0_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [REG_W-1:0] rdata_r;
	logic [1:0] rresp_r;

	tlip_arb_if arb ();

	// ==========================================================
	// source gating
	wire global_en = ie_main_r[GLOBAL_EN_BIT];
	wire [UPPER_SRC_W-1:0] upper_en = '0;
	wire [NUM_SRC-1:0] src_en = {upper_en, ie_ext1_r, ie_main_r[MAIN_SRC_W-1:0]};
	wire [NUM_SRC-1:0] src_gated = IRQ_PENDING & src_en & {NUM_SRC{global_en}};
	wire [NUM_SRC-MAIN_SRC_W-1:0] upper_low = '0;

	assign arb.req = src_gated;
	assign arb.high = {upper_low, ip_main_r};

	tlip_resolver u_resolver (
		.arb(arb.resolver)
	);

	// ==========================================================
	// preemption and vector
	wire win_hi_ok = arb.win_high & ~isr_hi_r;
	wire win_lo_ok = ~arb.win_high & ~isr_hi_r & ~isr_lo_r;
	wire eligible = arb.found & (win_hi_ok | win_lo_ok);
	wire [VEC_W-1:0] win_offset = VEC_W'({arb.win_idx, {VEC_SHIFT{1'b0}}});
	wire [VEC_W-1:0] win_vector = VEC_BASE + win_offset;

	// ==========================================================
	// call sequencer
	always_comb begin
		state_nxt = state_r;
		call_high_nxt = call_high_r;
		call_idx_nxt = call_idx_r;
		call_vec_nxt = call_vec_r;
		unique case (state_r)
			ST_IDLE: begin
				if (RETI_DONE) begin
					state_nxt = ST_HOLD;
				end else if (eligible) begin
					state_nxt = ST_CALL;
					call_high_nxt = arb.win_high;
					call_idx_nxt = arb.win_idx;
					call_vec_nxt = win_vector;
				end
			end
			ST_CALL: begin
				if (CALL_ACK) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (INSTR_DONE && eligible) begin
					state_nxt = ST_CALL;
					call_high_nxt = arb.win_high;
					call_idx_nxt = arb.win_idx;
					call_vec_nxt = win_vector;
				end else if (INSTR_DONE) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// in-service tracking, set wins over clear
	wire take_call = (state_r == ST_CALL) & CALL_ACK;
	wire clr_hi = RETI_DONE & isr_hi_r;
	wire clr_lo = RETI_DONE & ~isr_hi_r;

	always_comb begin
		isr_hi_nxt = isr_hi_r & ~clr_hi;
		isr_lo_nxt = isr_lo_r & ~clr_lo;
		if (take_call && call_high_r) begin
			isr_hi_nxt = 1'b1;
		end
		if (take_call && !call_high_r) begin
			isr_lo_nxt = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r <= ST_IDLE;
			isr_lo_r <= 1'b0;
			isr_hi_r <= 1'b0;
			call_high_r <= 1'b0;
			call_idx_r <= '0;
			call_vec_r <= '0;
		end else if (CLK_EN) begin
			state_r <= state_nxt;
			isr_lo_r <= isr_lo_nxt;
			isr_hi_r <= isr_hi_nxt;
			call_high_r <= call_high_nxt;
			call_idx_r <= call_idx_nxt;
			call_vec_r <= call_vec_nxt;
		end
	end

	assign CALL_REQ = (state_r == ST_CALL);
	assign CALL_VECTOR = call_vec_r;

	// ==========================================================
	// bus write channel
	wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
	wire w_take = S_AXI_WVALID & S_AXI_WREADY;
	wire do_write = aw_held_r & w_held_r & ~bvalid_r & CLK_EN;
	wire wr_en_main = (aw_idx_r == IDX_ENABLE_MAIN);
	wire wr_pr_main = (aw_idx_r == IDX_PRIORITY_MAIN);
	wire wr_en_ext1 = (aw_idx_r == IDX_ENABLE_EXT1);
	wire wr_status = (aw_idx_r == IDX_STATUS);
	wire wr_mapped = wr_en_main | wr_pr_main | wr_en_ext1 | wr_status;
	wire wr_store = do_write & w_lane0_r;

	assign S_AXI_AWREADY = ~aw_held_r & ~bvalid_r & CLK_EN;
	assign S_AXI_WREADY = ~w_held_r & ~bvalid_r & CLK_EN;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_held_r <= 1'b0;
			aw_idx_r <= '0;
			w_held_r <= 1'b0;
			w_data_r <= '0;
			w_lane0_r <= 1'b0;
		end else if (CLK_EN) begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				aw_idx_r <= S_AXI_AWADDR[ADDR_W-1:2];
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				w_data_r <= S_AXI_WDATA[REG_W-1:0];
				w_lane0_r <= S_AXI_WSTRB[0];
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (CLK_EN) begin
			if (do_write) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// configuration registers
	always_comb begin
		ie_main_nxt = ie_main_r;
		ip_main_nxt = ip_main_r;
		ie_ext1_nxt = ie_ext1_r;
		if (wr_store && wr_en_main) begin
			ie_main_nxt = w_data_r;
		end
		if (wr_store && wr_pr_main) begin
			ip_main_nxt = w_data_r[MAIN_SRC_W-1:0];
		end
		if (wr_store && wr_en_ext1) begin
			ie_ext1_nxt = w_data_r;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ie_main_r <= ENABLE_MAIN_RST;
			ip_main_r <= PRIORITY_MAIN_RST;
			ie_ext1_r <= ENABLE_EXT1_RST;
		end else if (CLK_EN) begin
			ie_main_r <= ie_main_nxt;
			ip_main_r <= ip_main_nxt;
			ie_ext1_r <= ie_ext1_nxt;
		end
	end

	// ==========================================================
	// bus read channel
	wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
	wire [WIDX_W-1:0] rd_idx = S_AXI_ARADDR[ADDR_W-1:2];
	wire rd_en_main = (rd_idx == IDX_ENABLE_MAIN);
	wire rd_pr_main = (rd_idx == IDX_PRIORITY_MAIN);
	wire rd_en_ext1 = (rd_idx == IDX_ENABLE_EXT1);
	wire rd_status = (rd_idx == IDX_STATUS);
	wire rd_mapped = rd_en_main | rd_pr_main | rd_en_ext1 | rd_status;
	wire [REG_W-1:0] pr_main_view = {PRIORITY_UNUSED_RD, ip_main_r};

	logic [REG_W-1:0] status_view;
	always_comb begin
		status_view = '0;
		status_view[ST_ISR_LO_BIT] = isr_lo_r;
		status_view[ST_ISR_HI_BIT] = isr_hi_r;
		status_view[ST_CALL_BIT] = CALL_REQ;
		status_view[ST_IDX_LSB +: IDX_W] = call_idx_r;
	end

	wire [REG_W-1:0] rd_value = ({REG_W{rd_en_main}} & ie_main_r)
		| ({REG_W{rd_pr_main}} & pr_main_view)
		| ({REG_W{rd_en_ext1}} & ie_ext1_r)
		| ({REG_W{rd_status}} & status_view);

	assign S_AXI_ARREADY = ~rvalid_r & CLK_EN;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RRESP = rresp_r;
	assign S_AXI_RDATA = {{(DATA_W-REG_W){1'b0}}, rdata_r};

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (CLK_EN) begin
			if (ar_take) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_value;
				rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				rvalid_r <= 1'b0;
			end
		end
	end

endmodule : tlip_top
`default_nettype wire
